// file: mmc_map.vh
`ifndef MMC_MAP_VH
`define MMC_MAP_VH

// Register byte offsets on the APB port
`define MMC_OFS_STATUS 12'h000
`define MMC_OFS_FLAGS 12'h004
`define MMC_OFS_MASK 12'h008
`define MMC_OFS_CTRL 12'h00C

// Status register fields
`define MMC_ST_DATA_NOT_READY 0
`define MMC_ST_LOW_POWER 1
`define MMC_ST_SERIAL_ACTIVE 2
`define MMC_ST_IN_RESET 3

// Flag and mask register fields
`define MMC_FL_READY 0
`define MMC_FL_RX_LOS 1
`define MMC_FL_TX_FAULT 2
`define MMC_FLAG_W 3

// Control register fields
`define MMC_CT_POWER_DOWN 0

// Reset values
`define MMC_MASK_RST 3'h0
`define MMC_CTRL_RST 1'h0
`define MMC_PIN_RST 5'h03

// Clock rate and documented times
`define MMC_CLK_HZ 20000000
`define MMC_T_INIT_MS 2000
`define MMC_T_RESET_INIT_US 2
`define MMC_INIT_CYCLES (`MMC_T_INIT_MS * (`MMC_CLK_HZ / 1000))
`define MMC_RESET_CYCLES (`MMC_T_RESET_INIT_US * (`MMC_CLK_HZ / 1000000))

`endif

// file: mmc_ctrl.v
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "mmc_map.vh"

// Pin input synchroniser: three stages, a change counts once the
// second and third stage agree
module mmc_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire CLK_I,          // System clock
  input wire SYS_RST_I,      // Synchronous reset
  input wire [W-1:0] d_i,    // Asynchronous inputs
  output reg [W-1:0] q_o     // Filtered inputs
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  integer k;

  // Shift chain and agreement filter
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      for (k = 0; k < W; k = k + 1) begin
        if (s2[k] == s3[k]) begin
          q_o[k] <= s3[k];
        end
      end
    end
  end
endmodule

// Latched flag bit: an event sets it, a host read of the reported
// value clears it, and a new event in the same cycle wins
module mmc_flag_bit (
  input wire CLK_I, // System clock
  input wire SYS_RST_I, // Synchronous reset
  input wire clr_i, // Module reset clears the flag
  input wire event_i, // Condition present this cycle
  input wire rd_clr_i, // Host read reported this flag
  output reg flag_o // Latched flag
);
  // Set wins over the read clear, so no event is lost
  always @(posedge CLK_I) begin
    if (SYS_RST_I || clr_i) begin
      flag_o <= 1'b0;
    end else if (event_i) begin
      flag_o <= 1'b1;
    end else if (rd_clr_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule

module mmc_ctrl #(
  parameter INIT_CYCLES = `MMC_INIT_CYCLES,
  parameter RESET_CYCLES = `MMC_RESET_CYCLES
) (
  input wire CLK_I,                 // System clock, 20 MHz
  input wire SYS_RST_I,             // Power-on reset, active high
  input wire PSEL_I,                // APB select
  input wire PENABLE_I,             // APB access phase
  input wire PWRITE_I,              // APB direction
  input wire [11:0] PADDR_I,        // APB byte address
  input wire [31:0] PWDATA_I,       // APB write data
  output wire PREADY_O,             // APB ready
  output reg [31:0] PRDATA_O,       // APB read data
  output wire PSLVERR_O,            // APB error on unmapped address
  input wire MODULE_RESET_IN_N_I,   // Module reset pin, active low
  input wire MODULE_SELECT_IN_N_I,  // Module select pin, active low
  input wire LOW_POWER_PIN_I,       // Low-power mode pin
  input wire RX_LOS_I,              // Receive signal-loss condition
  input wire TX_FAULT_I,            // Transmit fault condition
  output reg ATTENTION_OUT_N_O,     // Interrupt output, active low
  output reg PRESENT_OUT_N_O,       // Module present, active low
  output reg SERIAL_ACTIVE_O,       // Management bus may answer
  output reg LOW_POWER_O            // Lower power level in force
);
  localparam [31:0] INIT_LAST = INIT_CYCLES - 1;
  localparam [31:0] RST_LAST = RESET_CYCLES - 1;
  // Life-cycle states, one-hot
  localparam [2:0] ST_BOOT = 3'h1;
  localparam [2:0] ST_RUN = 3'h2;
  localparam [2:0] ST_HELD = 3'h4;

  wire [4:0] pins;
  wire mod_rst_n;
  wire sel_n;
  wire lp_pin;
  wire los;
  wire fault;
  reg [31:0] init_cnt;
  reg [31:0] next_init_cnt;
  reg [31:0] rst_cnt;
  reg in_reset;
  reg [2:0] state;
  reg [2:0] next_state;
  wire data_not_ready;
  wire [`MMC_FLAG_W-1:0] flags;
  wire [`MMC_FLAG_W-1:0] rd_clr;
  wire flags_read;
  reg [`MMC_FLAG_W-1:0] mask;
  reg power_down;
  reg [`MMC_FLAG_W-1:0] cond;
  wire setup;
  wire acc_wr;
  wire acc_rd;
  wire mapped;

  // Pins from outside the clock domain
  mmc_sync #(
    .W(5),
    .RST_VAL(`MMC_PIN_RST)
  ) u_sync (
    .CLK_I(CLK_I),
    .SYS_RST_I(SYS_RST_I),
    .d_i({TX_FAULT_I, RX_LOS_I, LOW_POWER_PIN_I, MODULE_SELECT_IN_N_I,
          MODULE_RESET_IN_N_I}),
    .q_o(pins)
  );
  assign mod_rst_n = pins[0];
  assign sel_n = pins[1];
  assign lp_pin = pins[2];
  assign los = pins[3];
  assign fault = pins[4];

  // APB decode; zero wait states
  assign setup = PSEL_I & ~PENABLE_I;
  assign acc_wr = PSEL_I & PENABLE_I & PWRITE_I & mapped;
  assign acc_rd = PSEL_I & PENABLE_I & ~PWRITE_I & mapped;
  assign mapped = (PADDR_I == `MMC_OFS_STATUS) |
                  (PADDR_I == `MMC_OFS_FLAGS) |
                  (PADDR_I == `MMC_OFS_MASK) |
                  (PADDR_I == `MMC_OFS_CTRL);
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

  // Reset pin must stay low a full pulse time before it is honoured
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rst_cnt <= 32'h00000000;
      in_reset <= 1'b0;
    end else if (mod_rst_n) begin
      rst_cnt <= 32'h00000000;
      in_reset <= 1'b0;
    end else if (rst_cnt >= RST_LAST) begin
      in_reset <= 1'b1;
    end else begin
      rst_cnt <= rst_cnt + 32'h00000001;
    end
  end

  // Life cycle: boot timer, running, held in module reset
  always @* begin
    next_state = state;
    next_init_cnt = init_cnt;
    case (state)
      ST_BOOT: begin
        next_init_cnt = init_cnt + 32'h00000001;
        if (init_cnt >= INIT_LAST) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_init_cnt = init_cnt;
      end
      ST_HELD: begin
        next_init_cnt = 32'h00000000;
        if (!in_reset) begin
          next_state = ST_BOOT;
        end
      end
      default: begin
        next_state = ST_BOOT;
        next_init_cnt = 32'h00000000;
      end
    endcase
    if (in_reset) begin
      next_state = ST_HELD;
      next_init_cnt = 32'h00000000;
    end
  end

  // Life-cycle registers; power-on restarts the boot timer
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state <= ST_BOOT;
      init_cnt <= 32'h00000000;
    end else begin
      state <= next_state;
      init_cnt <= next_init_cnt;
    end
  end

  // Data stays not ready until the boot timer has run out
  assign data_not_ready = (state != ST_RUN);

  // Conditions that raise flags; ready is a single event at boot end
  always @* begin
    cond = {`MMC_FLAG_W{1'b0}};
    cond[`MMC_FL_READY] = (state == ST_BOOT) && (init_cnt >= INIT_LAST) &&
                          !in_reset;
    cond[`MMC_FL_RX_LOS] = los & ~data_not_ready;
    cond[`MMC_FL_TX_FAULT] = fault & ~data_not_ready;
  end

  // A flags read clears only the bits it reported in its setup cycle
  assign flags_read = acc_rd && (PADDR_I == `MMC_OFS_FLAGS);
  assign rd_clr = {`MMC_FLAG_W{flags_read}} &
                  PRDATA_O[`MMC_FLAG_W-1:0];

  // One latch per flag
  mmc_flag_bit u_flag_ready (
    .CLK_I(CLK_I),
    .SYS_RST_I(SYS_RST_I),
    .clr_i(in_reset),
    .event_i(cond[`MMC_FL_READY]),
    .rd_clr_i(rd_clr[`MMC_FL_READY]),
    .flag_o(flags[`MMC_FL_READY])
  );

  mmc_flag_bit u_flag_rx_los (
    .CLK_I(CLK_I),
    .SYS_RST_I(SYS_RST_I),
    .clr_i(in_reset),
    .event_i(cond[`MMC_FL_RX_LOS]),
    .rd_clr_i(rd_clr[`MMC_FL_RX_LOS]),
    .flag_o(flags[`MMC_FL_RX_LOS])
  );

  mmc_flag_bit u_flag_tx_fault (
    .CLK_I(CLK_I),
    .SYS_RST_I(SYS_RST_I),
    .clr_i(in_reset),
    .event_i(cond[`MMC_FL_TX_FAULT]),
    .rd_clr_i(rd_clr[`MMC_FL_TX_FAULT]),
    .flag_o(flags[`MMC_FL_TX_FAULT])
  );

  // Software registers
  always @(posedge CLK_I) begin
    if (SYS_RST_I || in_reset) begin
      mask <= `MMC_MASK_RST;
      power_down <= `MMC_CTRL_RST;
    end else if (acc_wr) begin
      if (PADDR_I == `MMC_OFS_MASK) begin
        mask <= PWDATA_I[`MMC_FLAG_W-1:0];
      end
      if (PADDR_I == `MMC_OFS_CTRL) begin
        power_down <= PWDATA_I[`MMC_CT_POWER_DOWN];
      end
    end
  end

  // Read data captured in the setup cycle
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      PRDATA_O <= 32'h00000000;
    end else if (setup && !PWRITE_I) begin
      PRDATA_O <= 32'h00000000;
      case (PADDR_I)
        `MMC_OFS_STATUS: begin
          PRDATA_O[`MMC_ST_DATA_NOT_READY] <= data_not_ready;
          PRDATA_O[`MMC_ST_LOW_POWER] <= LOW_POWER_O;
          PRDATA_O[`MMC_ST_SERIAL_ACTIVE] <= SERIAL_ACTIVE_O;
          PRDATA_O[`MMC_ST_IN_RESET] <= in_reset;
        end
        `MMC_OFS_FLAGS: begin
          PRDATA_O[`MMC_FLAG_W-1:0] <= flags;
        end
        `MMC_OFS_MASK: begin
          PRDATA_O[`MMC_FLAG_W-1:0] <= mask;
        end
        `MMC_OFS_CTRL: begin
          PRDATA_O[`MMC_CT_POWER_DOWN] <= power_down;
        end
        default: begin
          PRDATA_O <= 32'h00000000;
        end
      endcase
    end
  end

  // Interrupt: low while any unmasked flag is pending
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ATTENTION_OUT_N_O <= 1'b1;
    end else begin
      ATTENTION_OUT_N_O <= ~|(flags & ~mask);
    end
  end

  // Present: low once out of power-on reset
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      PRESENT_OUT_N_O <= 1'b1;
    end else begin
      PRESENT_OUT_N_O <= 1'b0;
    end
  end

  // Bus answers only when selected, booted and not held in reset
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      SERIAL_ACTIVE_O <= 1'b0;
    end else begin
      SERIAL_ACTIVE_O <= ~sel_n & ~in_reset &
                         ~data_not_ready;
    end
  end

  // Lower power level by pin or by control bit
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      LOW_POWER_O <= 1'b0;
    end else begin
      LOW_POWER_O <= lp_pin | power_down;
    end
  end
endmodule

// file: mmc_ctrl_props.sv
`timescale 1ns/1ps
`include "mmc_map.vh"
module mmc_ctrl_props #(
  parameter INIT_CYCLES = 100
) (
  input wire CLK_I, // Clock
  input wire SYS_RST_I, // Reset
  input wire PSEL_I, // Select
  input wire PENABLE_I, // Enable
  input wire PWRITE_I, // Write
  input wire [11:0] PADDR_I, // Address
  input wire [31:0] PWDATA_I, // Data
  input wire MODULE_RESET_IN_N_I, // Reset pin
  input wire MODULE_SELECT_IN_N_I, // Select pin
  input wire LOW_POWER_PIN_I, // Low-power pin
  input wire RX_LOS_I, // Signal loss
  input wire TX_FAULT_I, // Fault
  input wire ATTENTION_OUT_N_O, // Interrupt
  input wire SERIAL_ACTIVE_O, // Bus answers
  input wire LOW_POWER_O // Low power
);
  reg [31:0] cnt;
  // Register accesses of interest
  wire acc = PSEL_I & PENABLE_I;
  wire rd_fl = acc & ~PWRITE_I & (PADDR_I == `MMC_OFS_FLAGS);
  wire wr_mk = acc & PWRITE_I & (PADDR_I == `MMC_OFS_MASK);
  wire wr_ct = acc & PWRITE_I & (PADDR_I == `MMC_OFS_CTRL);
  // Cycles since power-on reset
  always @(posedge CLK_I) cnt <= SYS_RST_I ? 32'h0 : cnt + 32'h1;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  a_init_done: assert property (
    cnt == INIT_CYCLES + 16 |-> SERIAL_ACTIVE_O && !ATTENTION_OUT_N_O)
    else $error("init late");
  a_sel_gate: assert property (
    MODULE_SELECT_IN_N_I [*6] |-> !SERIAL_ACTIVE_O)
    else $error("answers while deselected");
  a_lp_pin: assert property (
    LOW_POWER_PIN_I [*6] |-> LOW_POWER_O) else $error("pin low power late");
  a_pd_set: assert property (
    wr_ct && PWDATA_I[0] |-> ##[1:3] LOW_POWER_O) else $error("pd late");
  a_pd_clr: assert property (
    !LOW_POWER_PIN_I [*6] ##0 (wr_ct && !PWDATA_I[0]) |-> ##[1:3] !LOW_POWER_O)
    else $error("pd exit late");
  a_mask_all: assert property (
    wr_mk && PWDATA_I[2:0] == 3'h7 |-> ##[1:3] ATTENTION_OUT_N_O)
    else $error("mask ignored");
  a_rel_read: assert property (
    (!RX_LOS_I && !TX_FAULT_I) [*6] ##0 rd_fl |-> ##[1:3] ATTENTION_OUT_N_O)
    else $error("no release");
  a_flag_latched: assert property (
    disable iff (SYS_RST_I || !MODULE_RESET_IN_N_I)
    $rose(ATTENTION_OUT_N_O) |-> $past(rd_fl, 2) || $past(wr_mk, 2))
    else $error("released unread");
endmodule

bind mmc_ctrl mmc_ctrl_props #(.INIT_CYCLES(INIT_CYCLES)) u_props (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .MODULE_RESET_IN_N_I(MODULE_RESET_IN_N_I),
  .MODULE_SELECT_IN_N_I(MODULE_SELECT_IN_N_I),
  .LOW_POWER_PIN_I(LOW_POWER_PIN_I), .RX_LOS_I(RX_LOS_I),
  .TX_FAULT_I(TX_FAULT_I), .ATTENTION_OUT_N_O(ATTENTION_OUT_N_O),
  .SERIAL_ACTIVE_O(SERIAL_ACTIVE_O), .LOW_POWER_O(LOW_POWER_O));

// file: mmc_host_pins.sv
`timescale 1ns/1ps
module mmc_host_pins (
  input wire clk_i, // Clock
  input wire go_i, // Start reset pulse
  input wire [7:0] len_i, // Pulse length
  output wire reset_n_o // Module reset pin
);
  reg [7:0] left = 8'h0;
  // Hold the reset pin low for the commanded cycles
  always @(posedge clk_i) begin
    if (go_i)
      left <= len_i;
    else if (left != 8'h0)
      left <= left - 8'h1;
  end
  assign reset_n_o = (left == 8'h0);
endmodule

// file: mmc_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "mmc_map.vh"
module mmc_ctrl_tb_top;
  reg clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  reg sel_n = 1'h0, lp = 1'h0, rx = 1'h0, tx = 1'h0, go = 1'h0, err;
  reg [11:0] pa = 12'h0;
  reg [31:0] pwd = 32'h0, rd, b;
  reg [7:0] len = 8'h0;
  wire rdy, slverr, attn_n, act, lpo, rst_n, pres_n;
  wire [31:0] prd;
  int err_count = 0, samples_checked = 0, cyc = 0, i;
  mmc_ctrl #(.INIT_CYCLES(100), .RESET_CYCLES(8)) dut (.CLK_I(clk),
    .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(pa), .PWDATA_I(pwd), .PREADY_O(rdy), .PRDATA_O(prd),
    .PSLVERR_O(slverr), .MODULE_RESET_IN_N_I(rst_n),
    .MODULE_SELECT_IN_N_I(sel_n), .LOW_POWER_PIN_I(lp), .RX_LOS_I(rx),
    .TX_FAULT_I(tx), .ATTENTION_OUT_N_O(attn_n), .PRESENT_OUT_N_O(pres_n),
    .SERIAL_ACTIVE_O(act), .LOW_POWER_O(lpo));
  mmc_host_pins host (.clk_i(clk), .go_i(go), .len_i(len),
    .reset_n_o(rst_n));
  // Clock
  initial forever #25 clk = ~clk;
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_sim;
    end
  end
  task chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer, held until ready is sampled
  task apb(input bit w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (rdy !== 1'h1) @(posedge clk);
    rd = prd;
    err = slverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  function [31:0] exp_flags(input bit r, input bit t);
    exp_flags = ({31'h0, r} << `MMC_FL_RX_LOS) |
      ({31'h0, t} << `MMC_FL_TX_FAULT);
  endfunction
  // Read the flags, then see the interrupt released
  task rd_flags(input [31:0] e);
    apb(1'h0, `MMC_OFS_FLAGS, 32'h0);
    chk(rd === e, "flag value");
    tick(3);
    chk(attn_n === 1'h1, "interrupt held");
  endtask
  task pulse(input [7:0] n);
    @(posedge clk);
    len <= n;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h870e532c));
    tick(12);
    rst <= 1'h0;
    tick(50);
    chk(attn_n === 1'h1 && act === 1'h0 && pres_n === 1'h0, "boot");
    tick(70);
    chk(act === 1'h1 && attn_n === 1'h0, "not ready");
    apb(1'h0, `MMC_OFS_STATUS, 32'h0);
    chk(rd === (32'h1 << `MMC_ST_SERIAL_ACTIVE), "status");
    rd_flags(32'h1 << `MMC_FL_READY);
    rd_flags(32'h0);
    for (i = 0; i < 6; i++) begin
      b = $urandom;
      rx <= b[0];
      tx <= b[1] | ~b[0];
      tick(8);
      rx <= 1'h0;
      tx <= 1'h0;
      tick(8);
      chk(attn_n === 1'h0, "flag lost");
      tick(8);
      rd_flags(exp_flags(b[0], b[1] | ~b[0]));
    end
    apb(1'h1, `MMC_OFS_MASK, 32'h7);
    apb(1'h0, `MMC_OFS_MASK, 32'h0);
    chk(rd === 32'h7, "mask readback");
    rx <= 1'h1;
    tick(10);
    chk(attn_n === 1'h1, "masked flag");
    apb(1'h1, `MMC_OFS_MASK, 32'h0);
    tick(3);
    chk(attn_n === 1'h0, "unmask");
    rx <= 1'h0;
    tick(8);
    rd_flags(exp_flags(1'h1, 1'h0));
    apb(1'h1, `MMC_OFS_CTRL, 32'h1);
    apb(1'h0, `MMC_OFS_CTRL, 32'h0);
    chk(rd === 32'h1, "ctrl readback");
    tick(3);
    chk(lpo === 1'h1, "pd on");
    apb(1'h1, `MMC_OFS_CTRL, 32'h0);
    tick(3);
    chk(lpo === 1'h0, "pd off");
    lp <= 1'h1;
    tick(8);
    chk(lpo === 1'h1, "pin low power");
    lp <= 1'h0;
    apb(1'h0, 12'h010, 32'h0);
    chk(err === 1'h1 && rd === 32'h0, "unmapped");
    sel_n <= 1'h1;
    tick(8);
    chk(act === 1'h0, "deselect");
    sel_n <= 1'h0;
    tick(8);
    chk(act === 1'h1, "select");
    pulse(8'h3);
    tick(20);
    chk(act === 1'h1, "short reset taken");
    pulse(8'h28);
    tick(30);
    chk(act === 1'h0, "reset ignored");
    tick(140);
    chk(act === 1'h1 && attn_n === 1'h0, "reinit");
    end_sim;
  end
endmodule
